// ---- verilog/ptsc_trap.sv ----
// Trap flag, trap state bit, control register and passive forcing of seven outputs.
// Assumes an Avalon-MM master on clk_i and trap_input_n_i arriving asynchronously.
`timescale 1ns/100ps
module ptsc_trap
  import ptsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [17:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic [1:0] avs_response_o,
  input wire logic trap_input_n_i,
  input wire logic timer_a_zero_match_i,
  input wire logic timer_b_zero_match_i,
  input wire logic [5:0] modulation_result_i,
  input wire logic timer_b_modulation_result_i,
  input wire logic [5:0] passive_level_select_i,
  input wire logic timer_b_passive_level_select_i,
  output logic [5:0] timer_a_pin_o,
  output logic timer_b_pin_o,
  output logic trap_state_bit_o,
  output logic trap_flag_o,
  output logic irq_o
);
  logic [15:0] ctrl_r;
  logic [15:0] ctrl_nxt;
  logic flag_r;
  logic flag_nxt;
  logic state_r;
  logic state_nxt;
  logic [1:0] stat_r;
  logic [1:0] stat_nxt;
  logic [1:0] mask_r;
  logic [31:0] rdata_r;
  logic ack_r;
  logic sync1_r;
  logic sync2_r;
  logic [5:0] ta_q_r;
  logic tb_q_r;

  // Access is answered one cycle after it is presented; waitrequest drops then.
  wire req = (avs_read_i | avs_write_i) & ~ack_r;
  wire wr = avs_write_i & ack_r;
  wire hit_ctrl = (avs_address_i == PTSC_TRAP_CONTROL_ADDR);
  wire hit_stat = (avs_address_i == PTSC_STATUS_ADDR);
  wire hit_mask = (avs_address_i == PTSC_MASK_ADDR);
  wire hit_cmd = (avs_address_i == PTSC_COMMAND_ADDR);
  wire hit_any = hit_ctrl | hit_stat | hit_mask | hit_cmd;
  wire wr_lo = wr & avs_byteenable_i[0];
  wire wr_hi = wr & avs_byteenable_i[1];
  wire sw_set = wr_lo & hit_cmd & avs_writedata_i[PTSC_CMD_SET_BIT];
  wire sw_clr = wr_lo & hit_cmd & avs_writedata_i[PTSC_CMD_CLR_BIT];
  wire pin_en = ctrl_r[PTSC_PIN_EN_BIT];
  wire pin_trap = pin_en & ~sync2_r;
  wire clr_mode = ctrl_r[PTSC_CLR_MODE_BIT];
  wire [1:0] exit_sel = ctrl_r[1:0];
  wire hw_clr = ~clr_mode & ~pin_trap;
  wire sw_clr_ok = sw_clr & ~pin_trap;
  wire entry = (pin_trap | sw_set) & ~(flag_r & state_r);
  wire exit_hit = (exit_sel == PTSC_EXIT_TA) ? timer_a_zero_match_i :
    (exit_sel == PTSC_EXIT_TB) ? timer_b_zero_match_i :
    (exit_sel == PTSC_EXIT_NOW);
  wire release_ok = ~flag_r & exit_hit;
  wire [5:0] ta_force = {6{state_r}} & ctrl_r[PTSC_TA_EN_HI:PTSC_TA_EN_LO];
  wire tb_force = state_r & ctrl_r[PTSC_TB_EN_BIT];
  wire [1:0] ev = {state_r & release_ok & ~(pin_trap | sw_set), entry};
  wire [31:0] rd_mux = hit_ctrl ? {13'h0000, ~sync2_r, state_r, flag_r, ctrl_r} :
    hit_stat ? {30'h00000000, stat_r} :
    hit_mask ? {30'h00000000, mask_r} : 32'h00000000;

  always_comb
  begin
    ctrl_nxt = ctrl_r;
    if (wr_lo && hit_ctrl)
    begin
      ctrl_nxt[7:0] = avs_writedata_i[7:0] & PTSC_TRAP_CONTROL_MASK[7:0];
    end
    if (wr_hi && hit_ctrl)
    begin
      ctrl_nxt[15:8] = avs_writedata_i[15:8];
    end
  end

  always_comb
  begin
    flag_nxt = flag_r;
    if (pin_trap || sw_set)
    begin
      flag_nxt = 1'b1;
    end
    else if (hw_clr || sw_clr_ok)
    begin
      flag_nxt = 1'b0;
    end
  end

  always_comb
  begin
    state_nxt = state_r;
    if (pin_trap || sw_set)
    begin
      state_nxt = 1'b1;
    end
    else if (release_ok)
    begin
      state_nxt = 1'b0;
    end
  end

  // Set wins over a write-one clear in the same cycle.
  always_comb
  begin
    stat_nxt = stat_r;
    if (wr_lo && hit_stat)
    begin
      stat_nxt = stat_r & ~avs_writedata_i[1:0];
    end
    stat_nxt = stat_nxt | ev;
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      ctrl_r <= PTSC_TRAP_CONTROL_RST;
      flag_r <= 1'b0;
      state_r <= 1'b0;
      stat_r <= PTSC_STAT_RST;
      mask_r <= PTSC_STAT_RST;
      rdata_r <= 32'h00000000;
      ack_r <= 1'b0;
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
      ta_q_r <= 6'h00;
      tb_q_r <= 1'b0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      flag_r <= flag_nxt;
      state_r <= state_nxt;
      stat_r <= stat_nxt;
      if (wr_lo && hit_mask)
      begin
        mask_r <= avs_writedata_i[1:0];
      end
      ack_r <= req;
      if (req && avs_read_i)
      begin
        rdata_r <= rd_mux;
      end
      sync1_r <= trap_input_n_i;
      sync2_r <= sync1_r;
      // Enabled passive output drives its level; active drives the inverse.
      ta_q_r <= passive_level_select_i ^ (modulation_result_i & ~ta_force);
      tb_q_r <= timer_b_passive_level_select_i ^ (timer_b_modulation_result_i & ~tb_force);
    end
  end

  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_r;
  assign avs_readdata_o = rdata_r;
  assign avs_response_o = hit_any ? 2'b00 : 2'b10;
  assign trap_state_bit_o = state_r;
  assign trap_flag_o = flag_r;
  assign timer_a_pin_o = ta_q_r;
  assign timer_b_pin_o = tb_q_r;
  assign irq_o = |(stat_r & mask_r);

  trap_entry_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (pin_trap || sw_set) |=> (flag_r && state_r))
    else $error("trap entry did not set flag and state");
  pin_hold_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (pin_trap && sw_clr) |=> flag_r)
    else $error("flag cleared while trap pin low");
  hw_clear_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (flag_r && !clr_mode && !pin_trap && !sw_set) |=> !flag_r)
    else $error("flag not cleared by hardware");
  sw_keep_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (flag_r && clr_mode && !sw_clr) |=> flag_r)
    else $error("flag cleared without software in mode one");
  state_order_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ($fell(state_r)) |-> !$past(flag_r))
    else $error("state released while flag set");
  reserved_exit_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (state_r && exit_sel == PTSC_EXIT_RSVD) |=> state_r)
    else $error("reserved exit select released state");
  ta_exit_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (state_r && !flag_r && exit_sel == PTSC_EXIT_TA && !timer_a_zero_match_i) |=> state_r)
    else $error("timer A exit without zero match");
  tb_force_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (tb_force) |=> (tb_q_r == $past(timer_b_passive_level_select_i)))
    else $error("timer B output not passive in trap");
  pin_off_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (!pin_en && !sw_set && !flag_r) |=> !flag_r)
    else $error("disabled pin caused a trap");

  // Immediate exit leaves the trap state one edge after the flag is seen clear.
  now_exit_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (state_r && !flag_r && exit_sel == PTSC_EXIT_NOW && !pin_trap && !sw_set) |=> !state_r)
    else $error("immediate exit did not release state");

  // A pending timer A exit releases on the zero-match pulse itself.
  ta_release_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (state_r && !flag_r && exit_sel == PTSC_EXIT_TA && timer_a_zero_match_i
      && !pin_trap && !sw_set) |=> !state_r)
    else $error("timer A zero match did not release state");

  // Timer B synchronised exit waits for its own zero-match pulse.
  tb_exit_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (state_r && !flag_r && exit_sel == PTSC_EXIT_TB && !timer_b_zero_match_i) |=> state_r)
    else $error("timer B exit without zero match");

  // Every enabled timer A output shows its passive level one edge later.
  ta_force_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (|ta_force) |=> ((ta_q_r & $past(ta_force))
      == ($past(passive_level_select_i) & $past(ta_force))))
    else $error("timer A output not passive in trap");

  sw_set_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    sw_set |=> (flag_r && state_r))
    else $error("software set did not enter trap");

  // The entry event is latched even when software clears status in the same cycle.
  entry_event_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    entry |=> stat_r[PTSC_ST_ENTRY_BIT])
    else $error("trap entry event lost");

  reset_clear_a: assert property (@(posedge clk_i)
    !nrst_i |=> (ctrl_r == PTSC_TRAP_CONTROL_RST && !flag_r && !state_r))
    else $error("reset left trap state or control set");

  // A held request sees exactly one wait cycle.
  one_wait_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ((avs_read_i || avs_write_i) && avs_waitrequest_o) |=> !avs_waitrequest_o)
    else $error("bus request not answered after one wait cycle");
endmodule : ptsc_trap

// ---- verilog/ptsc_pkg.sv ----
// Constants for the PWM trap shutdown control block.
// Assumes one 200 MHz clock and a 32-bit Avalon-MM slave with word addressing by byte.
package ptsc_pkg;
  localparam logic [15:0] PTSC_TRAP_CONTROL_IDX = 16'he8c2;
  localparam logic [17:0] PTSC_TRAP_CONTROL_ADDR = {PTSC_TRAP_CONTROL_IDX, 2'b00};
  localparam logic [17:0] PTSC_STATUS_ADDR = 18'h00000;
  localparam logic [17:0] PTSC_MASK_ADDR = 18'h00004;
  localparam logic [17:0] PTSC_COMMAND_ADDR = 18'h00008;
  localparam logic [15:0] PTSC_TRAP_CONTROL_RST = 16'h0000;
  localparam int PTSC_PIN_EN_BIT = 15;
  localparam int PTSC_TB_EN_BIT = 14;
  localparam int PTSC_TA_EN_HI = 13;
  localparam int PTSC_TA_EN_LO = 8;
  localparam int PTSC_CLR_MODE_BIT = 2;
  localparam logic [15:0] PTSC_TRAP_CONTROL_MASK = 16'hff07;
  localparam int PTSC_ST_ENTRY_BIT = 0;
  localparam int PTSC_ST_EXIT_BIT = 1;
  localparam logic [1:0] PTSC_STAT_RST = 2'h0;
  localparam int PTSC_CMD_SET_BIT = 0;
  localparam int PTSC_CMD_CLR_BIT = 1;
  localparam int PTSC_RD_STATE_BIT = 17;
  localparam int PTSC_RD_FLAG_BIT = 16;
  localparam int PTSC_RD_PIN_BIT = 18;
  typedef enum logic [1:0]
  {
    PTSC_EXIT_TA = 2'b00,
    PTSC_EXIT_TB = 2'b01,
    PTSC_EXIT_RSVD = 2'b10,
    PTSC_EXIT_NOW = 2'b11
  } ptsc_exit_t;
endpackage : ptsc_pkg

// ---- bench/ptsc_stage.sv ----
// Power stage model that drives the active-low trap pin.
// Assumes the bench asks for a fault by holding fault_i high.
`timescale 1ns/100ps
module ptsc_stage (
  input wire logic clk_i,
  input wire logic fault_i,
  output logic trap_input_n_o
);
  initial trap_input_n_o = 1'b1;
  always @(posedge clk_i) trap_input_n_o <= ~fault_i;
endmodule : ptsc_stage

// ---- bench/ptsc_tb.sv ----
// Self-checking bench for the trap shutdown block.
// Assumes an Avalon-MM slave that answers by dropping waitrequest.
`timescale 1ns/100ps
module pwm_trap_shutdown_control_tb;
  import ptsc_pkg::*;
  logic clk_i = 0, nrst_i = 0, rd = 0, wr = 0, za = 0, zb = 0, flt = 0, wq, pb, st, fl, irq, pn;
  logic [17:0] adr = 0;
  logic [31:0] wd = 0, rdat, q;
  logic [5:0] pa;
  logic [1:0] rsp, rs;
  int mismatches = 0, n_compared = 0;
  ptsc_stage ps (.clk_i(clk_i), .fault_i(flt), .trap_input_n_o(pn));
  ptsc_trap uut (.clk_i(clk_i), .nrst_i(nrst_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hf), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wq), .avs_response_o(rsp), .trap_input_n_i(pn),
    .timer_a_zero_match_i(za), .timer_b_zero_match_i(zb), .modulation_result_i(6'h3f),
    .timer_b_modulation_result_i(1'b1), .passive_level_select_i(6'h15),
    .timer_b_passive_level_select_i(1'b1), .timer_a_pin_o(pa), .timer_b_pin_o(pb),
    .trap_state_bit_o(st), .trap_flag_o(fl), .irq_o(irq));
  initial
  begin
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
    n_compared++;
    if (g !== e)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [17:0] a, input logic [31:0] d);
    @(posedge clk_i);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= ~w;
    @(posedge clk_i);
    while (wq !== 1'b0) @(posedge clk_i);
    q = rdat;
    rs = rsp;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : acc
  task automatic pulse(input logic a, input logic b);
    @(posedge clk_i);
    za <= a;
    zb <= b;
    @(posedge clk_i);
    za <= 1'b0;
    zb <= 1'b0;
    @(negedge clk_i);
  endtask : pulse
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  initial
  begin
    #100000;
    mismatches++;
    print_verdict;
  end
  initial
  begin
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    acc(0, PTSC_TRAP_CONTROL_ADDR, 0);
    chk("ctrl", 34'h0, q);
    acc(1, PTSC_MASK_ADDR, 3);
    acc(1, PTSC_TRAP_CONTROL_ADDR, 32'hea03);
    flt <= 1'b1;
    repeat (6) @(negedge clk_i);
    chk("trap", 7, {st, fl, irq});
    chk("pins", 7'h40, {pb, pa});
    acc(1, PTSC_COMMAND_ADDR, 2);
    acc(1, PTSC_STATUS_ADDR, 3);
    @(negedge clk_i);
    chk("hold", 6, {st, fl, irq});
    @(posedge clk_i);
    flt <= 1'b0;
    repeat (7) @(negedge clk_i);
    chk("exit", 1, {st, fl, irq});
    chk("pins", 7'h2a, {pb, pa});
    acc(1, PTSC_STATUS_ADDR, 3);
    acc(0, 18'h00100, 0);
    chk("unmapped", {2'b10, 32'h0}, {rs, q});
    for (int m = 0; m < 3; m++)
    begin
      acc(1, PTSC_TRAP_CONTROL_ADDR, m);
      flt <= 1'b1;
      repeat (6) @(negedge clk_i);
      chk("pin off", 0, {st, fl});
      @(posedge clk_i);
      flt <= 1'b0;
      acc(1, PTSC_COMMAND_ADDR, 1);
      @(negedge clk_i);
      chk("sw set", 3, {st, fl});
      chk("no enable", 7'h2a, {pb, pa});
      acc(1, PTSC_COMMAND_ADDR, 2);
      pulse(m == 1, m != 1);
      chk("held", 2, {st, fl});
      pulse(m != 1, m == 1);
      chk("sync exit", m == 2 ? 2 : 0, {st, fl});
      @(posedge clk_i);
      nrst_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      nrst_i <= 1'b1;
    end
    acc(1, PTSC_TRAP_CONTROL_ADDR, 32'h8007);
    flt <= 1'b1;
    repeat (6) @(posedge clk_i);
    flt <= 1'b0;
    repeat (6) @(negedge clk_i);
    chk("sticky", 3, {st, fl});
    acc(1, PTSC_COMMAND_ADDR, 2);
    repeat (2) @(negedge clk_i);
    chk("sw clear", 0, {st, fl});
    print_verdict;
  end
endmodule : pwm_trap_shutdown_control_tb
